// File: core/ctr_pkg.sv
package ctr_pkg;

  // Bus and datapath widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 24;

  // Register offsets
  localparam logic [7:0] CTRL_OFS   = 8'h8C;
  localparam logic [7:0] COUNT_OFS  = 8'h90;
  localparam logic [7:0] STATUS_OFS = 8'hA0;
  localparam logic [7:0] MASK_OFS   = 8'hA4;

  // Control field positions, and the done bit of status and mask
  localparam int EN_BIT    = 31;
  localparam int IRQEN_BIT = 30;
  localparam int CLR_BIT   = 29;
  localparam int DIV_LSB   = 8;
  localparam int MODE_BIT  = 5;
  localparam int EXP_LSB   = 2;
  localparam int LOW_LSB   = 0;
  localparam int DONE_BIT  = 0;

  // Writable control bits and reset values
  localparam logic [31:0] CTRL_WMASK = 32'hE000_FF3F;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic        STATUS_RST = 1'b0;
  localparam logic        MASK_RST   = 1'b0;

  // Discharge lengths in clock cycles per encoding
  localparam logic [4:0] LOW_CYC0 = 5'h01;
  localparam logic [4:0] LOW_CYC1 = 5'h02;
  localparam logic [4:0] LOW_CYC2 = 5'h08;
  localparam logic [4:0] LOW_CYC3 = 5'h10;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CHARGE,
    ST_DISCH,
    ST_DONE
  } ctr_state_t;

  // Whole state of the sense top
  typedef struct packed {
    ctr_state_t  state;
    logic [31:0] ctrl;
    logic [23:0] count;
    logic [7:0]  cycle_exponent;
    logic [4:0]  lowLeft;
    logic        status;
    logic        mask;
    logic [7:0]  dischargeEn;
    logic        irq;
    logic [31:0] rdata;
  } ctr_sense_state_t;

  // Whole state of the reference clock divider
  typedef struct packed {
    logic       sdPrev;
    logic [7:0] cnt;
    logic       refOut;
  } ctr_div_state_t;

endpackage

// File: core/ctr_div_if.sv
`timescale 1ns/1ps

// Link between the sense top and its reference clock divider
interface ctr_div_if;
  logic       run;
  logic [7:0] divider;
  logic       sigma_delta_clock;
  logic       refClk;

  modport master (output run, output divider, output sigma_delta_clock, input refClk);
  modport slave (input run, input divider, input sigma_delta_clock, output refClk);
endinterface

// File: core/ctr_refclk_div.sv
`timescale 1ns/1ps

module ctr_refclk_div (
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst_b,
  // Divider link
  ctr_div_if.slave    div
);

  ctr_pkg::ctr_div_state_t s;
  ctr_pkg::ctr_div_state_t n;

  // Toggle every divider+1 rising edges of the sigma-delta clock
  always_comb begin
    n = s;
    n.sdPrev = div.sigma_delta_clock;
    if (!div.run) begin
      n.cnt = 8'h00;
      n.refOut = 1'b0;
    end else if (div.sigma_delta_clock && !s.sdPrev) begin
      if (s.cnt == div.divider) begin
        n.cnt = 8'h00;
        n.refOut = !s.refOut;
      end else begin
        n.cnt = s.cnt + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign div.refClk = s.refOut;

  // While running, output only changes on a completed divide count
  chk_refclk_toggle: assert property (@(posedge clk)
    disable iff (!rst_b)
    (div.run && $past(div.run) && $changed(s.refOut))
      |-> ($past(s.cnt) == $past(div.divider)))
    else $error("reference clock toggled off its divide count");

endmodule

// File: core/ctr_sense_top.sv
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps

module ctr_sense_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Analog front end
  input  wire logic        cmpHigh,
  input  wire logic [2:0]  senseSel,
  input  wire logic        sigma_delta_clock,
  output logic      [7:0]  dischargeEn,
  // Interrupt
  output logic             touchIrq
);

  ctr_pkg::ctr_sense_state_t s;
  ctr_pkg::ctr_sense_state_t n;
  ctr_div_if                 divBus ();

  logic       enBit;
  logic       irqEnBit;
  logic       clrBit;
  logic       modeBit;
  logic [2:0] cycleExp;
  logic [1:0] lowSel;
  logic [7:0] divField;
  logic       run;
  logic [7:0] target;
  logic [4:0] lowLoad;
  logic [7:0] pinOneHot;
  logic [7:0] cycleInc;
  logic       doneEvt;

  // Control fields
  assign enBit    = s.ctrl[ctr_pkg::EN_BIT];
  assign irqEnBit = s.ctrl[ctr_pkg::IRQEN_BIT];
  assign clrBit   = s.ctrl[ctr_pkg::CLR_BIT];
  assign modeBit  = s.ctrl[ctr_pkg::MODE_BIT];
  assign cycleExp = s.ctrl[ctr_pkg::EXP_LSB +: 3];
  assign lowSel   = s.ctrl[ctr_pkg::LOW_LSB +: 2];
  assign divField = s.ctrl[ctr_pkg::DIV_LSB +: 8];

  // Sensing runs only when enabled, released and in touch mode
  assign run       = enBit && !clrBit && !modeBit;
  assign target    = 8'h01 << cycleExp;
  assign pinOneHot = 8'h01 << senseSel;
  assign cycleInc  = s.cycle_exponent + 8'h01;

  // Discharge length decode
  always_comb begin
    case (lowSel)
      2'h0:    lowLoad = ctr_pkg::LOW_CYC0;
      2'h1:    lowLoad = ctr_pkg::LOW_CYC1;
      2'h2:    lowLoad = ctr_pkg::LOW_CYC2;
      2'h3:    lowLoad = ctr_pkg::LOW_CYC3;
      default: lowLoad = ctr_pkg::LOW_CYC0;
    endcase
  end

  // Last discharge of the last programmed cycle
  assign doneEvt = run && (s.state == ctr_pkg::ST_DISCH) &&
                   (s.lowLeft == 5'h01) && (cycleInc == target);

  // Reference clock divider link
  assign divBus.run     = enBit && modeBit;
  assign divBus.divider = divField;
  assign divBus.sigma_delta_clock   = sigma_delta_clock;

  ctr_refclk_div u_div (
    .clk   (clk),
    .rst_b (rst_b),
    .div   (divBus)
  );

  // Next state: registers, sequencer, interrupt and outputs
  always_comb begin
    n = s;
    // Register writes
    if (regWr) begin
      case (regAddr)
        ctr_pkg::CTRL_OFS: begin
          n.ctrl = regWdata & ctr_pkg::CTRL_WMASK;
        end
        ctr_pkg::MASK_OFS: begin
          n.mask = regWdata[ctr_pkg::DONE_BIT];
        end
        default: begin
        end
      endcase
    end
    // Sequencer
    if (!run) begin
      n.state    = ctr_pkg::ST_IDLE;
      n.cycle_exponent = 8'h00;
      n.lowLeft  = 5'h00;
      if (!enBit || clrBit) begin
        n.count = 24'h00_0000;
      end
    end else begin
      case (s.state)
        ctr_pkg::ST_IDLE: begin
          n.state = ctr_pkg::ST_CHARGE;
        end
        ctr_pkg::ST_CHARGE: begin
          if (cmpHigh) begin
            n.state   = ctr_pkg::ST_DISCH;
            n.lowLeft = lowLoad;
          end else begin
            n.count = s.count + 24'h00_0001;
          end
        end
        ctr_pkg::ST_DISCH: begin
          if (s.lowLeft == 5'h01) begin
            n.cycle_exponent = cycleInc;
            n.lowLeft  = 5'h00;
            if (cycleInc == target) begin
              n.state = ctr_pkg::ST_DONE;
            end else begin
              n.state = ctr_pkg::ST_CHARGE;
            end
          end else begin
            n.lowLeft = s.lowLeft - 5'h01;
          end
        end
        ctr_pkg::ST_DONE: begin
          n.state = ctr_pkg::ST_DONE;
        end
        default: begin
          n.state = ctr_pkg::ST_IDLE;
        end
      endcase
    end
    // Sticky done flag; a new event beats any clear
    if (regWr && (regAddr == ctr_pkg::STATUS_OFS) &&
        regWdata[ctr_pkg::DONE_BIT]) begin
      n.status = 1'b0;
    end
    if (!irqEnBit || !enBit || clrBit) begin
      n.status = 1'b0;
    end
    if (doneEvt && irqEnBit) begin
      n.status = 1'b1;
    end
    n.irq = n.status && n.mask && n.ctrl[ctr_pkg::IRQEN_BIT];
    // Pin drive: divided clock in reference mode, discharge otherwise
    if (n.ctrl[ctr_pkg::EN_BIT] && n.ctrl[ctr_pkg::MODE_BIT]) begin
      n.dischargeEn = divBus.refClk ? pinOneHot : 8'h00;
    end else if (n.state == ctr_pkg::ST_DISCH) begin
      n.dischargeEn = pinOneHot;
    end else begin
      n.dischargeEn = 8'h00;
    end
    // Read data stands for one cycle only
    n.rdata = 32'h0000_0000;
    if (regRd) begin
      case (regAddr)
        ctr_pkg::CTRL_OFS:   n.rdata = s.ctrl;
        ctr_pkg::COUNT_OFS:  n.rdata = {8'h00, s.count};
        ctr_pkg::STATUS_OFS: n.rdata = {31'h0000_0000, s.status};
        ctr_pkg::MASK_OFS:   n.rdata = {31'h0000_0000, s.mask};
        default:             n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s.state       <= ctr_pkg::ST_IDLE;
      s.ctrl        <= ctr_pkg::CTRL_RST;
      s.count       <= 24'h00_0000;
      s.cycle_exponent    <= 8'h00;
      s.lowLeft     <= 5'h00;
      s.status      <= ctr_pkg::STATUS_RST;
      s.mask        <= ctr_pkg::MASK_RST;
      s.dischargeEn <= 8'h00;
      s.irq         <= 1'b0;
      s.rdata       <= 32'h0000_0000;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from flip-flops
  assign regRdata    = s.rdata;
  assign dischargeEn = s.dischargeEn;
  assign touchIrq    = s.irq;

  // Comparator trip drives the selected pin low next cycle
  chk_discharge_on_trip: assert property (@(posedge clk)
    disable iff (!rst_b)
    (run && !regWr && s.state == ctr_pkg::ST_CHARGE && cmpHigh)
      |=> (dischargeEn == (8'h01 << $past(senseSel))))
    else $error("pin not discharged after comparator trip");

  // Done only after the programmed cycle total
  chk_cycle_total: assert property (@(posedge clk)
    disable iff (!rst_b)
    $rose(s.state == ctr_pkg::ST_DONE) |-> (s.cycle_exponent == target))
    else $error("done reached with wrong cycle total");

  // Counter advances by one per charging cycle
  chk_count_charge: assert property (@(posedge clk)
    disable iff (!rst_b)
    (run && !regWr && s.state == ctr_pkg::ST_CHARGE && !cmpHigh)
      |=> (s.count == $past(s.count) + 24'h00_0001))
    else $error("count did not advance while charging");

  // Counter frozen during discharge
  chk_count_disch: assert property (@(posedge clk)
    disable iff (!rst_b)
    (s.state == ctr_pkg::ST_DISCH && !regWr)
      |=> (s.count == $past(s.count)))
    else $error("count moved during discharge");

  // Disabled block is held in reset
  chk_disable_reset: assert property (@(posedge clk)
    disable iff (!rst_b)
    (!enBit && !regWr) |=> (s.count == 24'h00_0000 && dischargeEn == 8'h00
      && !touchIrq && s.state == ctr_pkg::ST_IDLE))
    else $error("disabled block not held in reset");

  // Interrupt disable drops pending state
  chk_irq_disable: assert property (@(posedge clk)
    disable iff (!rst_b)
    (!irqEnBit && !regWr) |=> (!touchIrq && !s.status))
    else $error("interrupt pending while disabled");

  // Count clear holds zero
  chk_clear_zero: assert property (@(posedge clk)
    disable iff (!rst_b)
    (clrBit && !regWr) |=> (s.count == 24'h00_0000))
    else $error("count not held at zero by clear");

  // Code two gives eight discharge cycles
  chk_low_eight: assert property (@(posedge clk)
    disable iff (!rst_b || regWr)
    (run && s.state == ctr_pkg::ST_CHARGE && cmpHigh && lowSel == 2'h2)
      |=> (s.state == ctr_pkg::ST_DISCH) [*8] ##1
          (s.state != ctr_pkg::ST_DISCH))
    else $error("discharge length wrong for code two");

  // Finished count holds and stays flagged
  chk_done_hold: assert property (@(posedge clk)
    disable iff (!rst_b)
    (s.state == ctr_pkg::ST_DONE && run && !regWr)
      |=> (s.count == $past(s.count) && s.state == ctr_pkg::ST_DONE))
    else $error("count changed after done");

  // Count read shows count with zero upper byte
  chk_count_read: assert property (@(posedge clk)
    disable iff (!rst_b)
    (regRd && regAddr == ctr_pkg::COUNT_OFS)
      |=> (regRdata == {8'h00, $past(s.count)}))
    else $error("count read data wrong");

  // Reserved control bits read zero
  chk_reserved_zero: assert property (@(posedge clk)
    disable iff (!rst_b)
    (regRd && regAddr == ctr_pkg::CTRL_OFS)
      |=> ((regRdata & ~ctr_pkg::CTRL_WMASK) == 32'h0000_0000))
    else $error("reserved control bits read nonzero");

  // Reference mode leaves the count alone
  chk_ref_count_hold: assert property (@(posedge clk)
    disable iff (!rst_b)
    (enBit && modeBit && !clrBit && !regWr) |=> (s.count == $past(s.count)))
    else $error("count moved in reference mode");

  // Main scenarios
  cov_measure_done: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(s.state == ctr_pkg::ST_DONE));
  cov_irq_raised: cover property (@(posedge clk) disable iff (!rst_b)
    $rose(touchIrq));
  cov_ref_clock: cover property (@(posedge clk) disable iff (!rst_b)
    (modeBit && enBit && $rose(dischargeEn != 8'h00)));
  cov_long_low: cover property (@(posedge clk) disable iff (!rst_b)
    (s.state == ctr_pkg::ST_DISCH && lowSel == 2'h3));

endmodule

// File: dv/ctr_pad_model.sv
`timescale 1ns/1ps

module ctr_pad_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Software set-up of pad and source
  input  wire logic       srcOn,
  input  wire logic [4:0] thr,
  input  wire logic [2:0] senseSel,
  // Pad, comparator and modulator clock
  input  wire logic [7:0] dischargeEn,
  output logic            cmpHigh,
  output logic            sigma_delta_clock
);
  logic [5:0] volt;
  logic [1:0] sdDiv;

  // Pad charges from the source, pulled to 0 V while discharged
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      volt <= 6'h00;
    end else if (!srcOn || dischargeEn[senseSel]) begin
      volt <= 6'h00;
    end else if (volt != 6'h3F) begin
      volt <= volt + 6'h01;
    end
  end

  // Comparator 0 on the sensed pin against the reference
  assign cmpHigh = (volt >= {1'h0, thr});

  // Free running modulator clock, four clk periods
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sdDiv <= 2'h0;
    end else begin
      sdDiv <= sdDiv + 2'h1;
    end
  end
  assign sigma_delta_clock = sdDiv[1];
endmodule

// File: dv/cap_touch_relaxation_counter_tb_top.sv
`timescale 1ns/1ps

module cap_touch_relaxation_counter_tb_top;
  logic        clk, rst_b, regWr, regRd, cmpHigh, sigma_delta_clock, touchIrq;
  logic        srcOn, touchMode, prevOut, hit;
  logic [7:0]  regAddr, dischargeEn;
  logic [31:0] regWdata, regRdata, rd, ctl, cnt, rnd;
  logic [2:0]  senseSel;
  logic [4:0]  thr;
  logic [7:0]  ofs [4] = '{8'h8C, 8'h90, 8'hA0, 8'hA4};
  int          error_cnt, tests_run, cyc, runLen, dischCnt, expLow, nCyc;
  int          t0, seed, d;

  ctr_sense_top u_dut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .cmpHigh(cmpHigh), .senseSel(senseSel),
    .sigma_delta_clock(sigma_delta_clock), .dischargeEn(dischargeEn), .touchIrq(touchIrq));

  ctr_pad_model u_pad (.clk(clk), .rst_b(rst_b), .srcOn(srcOn), .thr(thr),
    .senseSel(senseSel), .dischargeEn(dischargeEn), .cmpHigh(cmpHigh),
    .sigma_delta_clock(sigma_delta_clock));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    regWr    <= 1'h1;
    regAddr  <= a;
    regWdata <= dat;
    @(posedge clk);
    regWr <= 1'h0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    regRd   <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'h0;
    #1 rd = regRdata;
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Next rising edge of the selected output
  task automatic waitRise;
    for (int n = 0; n < 500; n++) begin
      @(negedge clk);
      hit = (prevOut === 1'h0 && dischargeEn[senseSel] === 1'h1);
      prevOut = dischargeEn[senseSel];
      if (hit) break;
    end
  endtask

  function automatic int lowTab(input logic [1:0] c);
    case (c)
      2'h0: return 1;
      2'h1: return 2;
      2'h2: return 8;
      default: return 16;
    endcase
  endfunction

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      finish_test();
    end
  end

  // Discharge pulse length, pin and count
  always @(negedge clk) begin
    if (touchMode && dischargeEn !== 8'h00) begin
      runLen++;
      if (runLen == 1) check(dischargeEn, 8'h01 << senseSel);
    end else if (touchMode && runLen != 0) begin
      check(runLen, expLow);
      dischCnt++;
      runLen = 0;
    end
  end

  initial begin
    seed = 37;
    {rst_b, regWr, regRd, srcOn, touchMode} = 5'h00;
    {regAddr, regWdata, senseSel} = 43'h0;
    thr = 5'h0A;
    prevOut = 1'h1;
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    // Reset values, reserved bits, read-only and unmapped places
    for (int i = 0; i < 4; i++) begin
      rdr(ofs[i]);
      check(rd, 32'h0000_0000);
    end
    wr(8'h8C, 32'h1FFF_00C0);
    rdr(8'h8C);
    check(rd, 32'h0000_0000);
    wr(8'h8C, 32'hFFFF_FFFF);
    rdr(8'h8C);
    check(rd, 32'hE000_FF3F);
    wr(8'h90, $random(seed));
    rdr(8'h90);
    check(rd, 32'h0000_0000);
    wr(8'h10, 32'hFFFF_FFFF);
    rdr(8'h10);
    check(rd, 32'h0000_0000);
    wr(8'h8C, 32'h0000_0000);
    wr(8'hA4, 32'h0000_0001);
    $display("Test registers done");
    // Touch measurements with corner and random settings
    for (int k = 0; k < 6; k++) begin
      rnd = $random(seed);
      ctl = 32'hE000_0000 | (rnd & 32'h0000_001F);
      if (k == 0) ctl = 32'hE000_0000;
      if (k == 1) ctl = 32'hE000_001F;
      if (k == 2) ctl = 32'hE000_000A;
      if (k == 3) ctl = 32'hE000_0005;
      expLow = lowTab(ctl[1:0]);
      nCyc = 1 << ctl[4:2];
      @(posedge clk);
      senseSel <= rnd[10:8];
      thr      <= {2'h1, rnd[13:11]};
      wr(8'h8C, ctl);
      rdr(8'h90);
      check(rd, 32'h0000_0000);
      touchMode = 1'h1;
      dischCnt = 0;
      @(posedge clk);
      srcOn <= 1'h1;
      wr(8'h8C, ctl & 32'hDFFF_FFFF);
      t0 = cyc;
      while (touchIrq !== 1'h1 && cyc - t0 < 8000) @(posedge clk);
      waitCyc(2);
      check(touchIrq, 1'h1);
      check(dischCnt, nCyc);
      rdr(8'h90);
      cnt = rd;
      check(rd[31:24], 8'h00);
      check(rd >= nCyc * (int'(thr) - 3) - 4 &&
            rd <= nCyc * (int'(thr) + 3), 1'h1);
      waitCyc(20);
      rdr(8'h90);
      check(rd, cnt);
      rdr(8'hA0);
      check(rd, 32'h0000_0001);
      wr(8'hA4, 32'h0000_0000);
      waitCyc(2);
      check(touchIrq, 1'h0);
      wr(8'hA4, 32'h0000_0001);
      waitCyc(2);
      check(touchIrq, 1'h1);
      if (k % 4 == 0) wr(8'hA0, 32'h0000_0001);
      if (k % 4 == 1) wr(8'h8C, ctl & 32'h9FFF_FFFF);
      if (k % 4 == 2) wr(8'h8C, 32'h0000_0000);
      if (k % 4 == 3) wr(8'h8C, ctl);
      waitCyc(2);
      check(touchIrq, 1'h0);
      rdr(8'hA0);
      check(rd, 32'h0000_0000);
      rdr(8'h90);
      check(rd, (k % 4 >= 2) ? 32'h0000_0000 : cnt);
      touchMode = 1'h0;
      @(posedge clk);
      srcOn <= 1'h0;
      $display("Test touch %0d done", k);
    end
    // Reference clock periods
    for (int k = 0; k < 3; k++) begin
      rnd = $random(seed);
      d = (k < 2) ? k : int'(rnd[2:0]) + 2;
      wr(8'h8C, 32'h8000_0020 | (d << 8));
      prevOut = 1'h1;
      waitRise();
      t0 = cyc;
      waitRise();
      check(cyc - t0, 8 * (d + 1));
      wr(8'h8C, 32'h0000_0000);
      $display("Test refclk %0d done", k);
    end
    finish_test();
  end
endmodule
